// >>> pkg/tcc_pkg.sv
// Purpose: constants for the timer capture/compare channel block
// Assumes: Avalon-MM word registers, 25 MHz system clock
// Notes: byte addresses are four times the printed register index
package tcc_pkg;
  // Register indices as printed; byte address is index times four
  localparam logic [7:0] IDX_CH0_LOW = 8'hDA;
  localparam logic [7:0] IDX_CH0_HIGH = 8'hDB;
  localparam logic [7:0] IDX_CH1_LOW = 8'hDC;
  localparam logic [7:0] IDX_CH1_HIGH = 8'hDD;
  localparam logic [7:0] IDX_CTL0 = 8'hE5;
  localparam logic [7:0] IDX_CTL1 = 8'hE6;
  localparam logic [7:0] IDX_TIMER = 8'hF0;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hF1;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hF2;
  localparam logic [7:0] IDX_COUNT = 8'hF3;
  // Control field positions
  localparam int SRC_SEL_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int ACT_LSB = 3;
  localparam int MODE_BIT = 2;
  localparam int EDGE_LSB = 0;
  // Reset values
  localparam logic [7:0] CTL_RESET = 8'h40;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  // Output action codes
  localparam logic [2:0] ACT_SET = 3'h0;
  localparam logic [2:0] ACT_CLR = 3'h1;
  localparam logic [2:0] ACT_TOG = 3'h2;
  localparam logic [2:0] ACT_SET_UP = 3'h3;
  localparam logic [2:0] ACT_CLR_UP = 3'h4;
  localparam logic [2:0] ACT_SET_CH0 = 3'h5;
  localparam logic [2:0] ACT_CLR_CH0 = 3'h6;
  localparam logic [2:0] ACT_DSM = 3'h7;
  // Counting modes
  localparam logic [1:0] TM_STOP = 2'h0;
  localparam logic [1:0] TM_FREE = 2'h1;
  localparam logic [1:0] TM_MOD = 2'h2;
  localparam logic [1:0] TM_UPDN = 2'h3;
  // Modulator divide counts
  localparam logic [2:0] DSM_DIV_SLOW = 3'h7;
  localparam logic [2:0] DSM_DIV_FAST = 3'h3;
endpackage

// >>> design/tcc_channel.sv
// Purpose: one capture/compare channel output and capture logic
// Assumes: inputs synchronous to clk, tick marks a counter update
// Notes: the mode and edge fields come straight from the control byte
`timescale 1ns/10ps
module tcc_channel
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [7:0] ctl,
  input wire logic [15:0] count,
  input wire logic down,
  input wire logic [15:0] cmp_val,
  input wire logic term_hit,
  input wire logic cap_in,
  input wire logic radio_evt,
  output logic out_level,
  output logic cap_evt,
  output logic cmp_evt
);
  logic out_r;
  logic out_nxt;
  logic cap_prev_r;
  logic [2:0] act;
  logic cmp_mode;
  logic [1:0] edge_sel;
  logic match;
  logic rise;
  logic fall;
  logic edge_hit;

  // Field decode
  assign act = ctl[tcc_pkg::ACT_LSB +: 3];
  assign cmp_mode = ctl[tcc_pkg::MODE_BIT];
  assign edge_sel = ctl[tcc_pkg::EDGE_LSB +: 2];
  assign match = tick && cmp_mode && (count == cmp_val); // see [RL19]
  assign rise = cap_in && !cap_prev_r;
  assign fall = !cap_in && cap_prev_r;
  // Radio events are already pulses, so every edge choice except none takes them
  assign edge_hit = ctl[tcc_pkg::SRC_SEL_BIT] ? radio_evt : // see [RL1]
    ((edge_sel[0] && rise) || (edge_sel[1] && fall)); // see [RL12]
  assign cap_evt = !cmp_mode && (edge_sel != 2'h0) && edge_hit; // see [RL11]
  assign cmp_evt = match;
  assign out_level = out_r;

  // Output action decode
  always_comb
  begin
    out_nxt = out_r;
    case (act)
      tcc_pkg::ACT_SET: if (match) out_nxt = 1'b1; // see [RL3]
      tcc_pkg::ACT_CLR: if (match) out_nxt = 1'b0; // see [RL3]
      tcc_pkg::ACT_TOG: if (match) out_nxt = !out_r; // see [RL3]
      tcc_pkg::ACT_SET_UP:
      begin
        if (match) out_nxt = !down; // see [RL4]
        else if (tick && cmp_mode && count == tcc_pkg::CNT_ZERO && !down) out_nxt = 1'b0;
      end
      tcc_pkg::ACT_CLR_UP:
      begin
        if (match) out_nxt = down; // see [RL5]
        else if (tick && cmp_mode && count == tcc_pkg::CNT_ZERO && !down) out_nxt = 1'b1;
      end
      tcc_pkg::ACT_SET_CH0:
      begin
        if (match) out_nxt = 1'b1; // see [RL7]
        else if (tick && cmp_mode && term_hit) out_nxt = 1'b0;
      end
      tcc_pkg::ACT_CLR_CH0:
      begin
        if (match) out_nxt = 1'b0; // see [RL8]
        else if (tick && cmp_mode && term_hit) out_nxt = 1'b1;
      end
      default: out_nxt = out_r;
    endcase
  end

  // Output and edge history
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_r <= 1'b0;
      cap_prev_r <= 1'b0;
    end
    else
    begin
      out_r <= out_nxt;
      cap_prev_r <= cap_in;
    end
  end
endmodule

// >>> design/tcc_top.sv
// Purpose: timer capture/compare channels 0 and 1 with delta-sigma output
// Assumes: Avalon-MM slave, one 25 MHz clock, synchronous pin inputs
// Notes: a small internal counter stands in for the shared timer counter
//
// Summary of operation
// [RL1] Capture source: pin or enabled radio events
// [RL2] Channel interrupt mask resets enabled
// [RL3] Codes 000/001/010 set, clear, toggle
// [RL4] Code 011 set up-match, clear zero/down
// [RL5] Code 100 clear up-match, set zero/down
// [RL6] Software avoids channel 0 codes 101-111
// [RL7] Channel 1 code 101: set own, clear ch0
// [RL8] Channel 1 code 110: clear own, set ch0
// [RL9] Code 111 modulator; speed 1/8 or 1/4
// [RL10] Edge field sets interpolator and shaping
// [RL11] Mode bit: 0 capture, 1 compare
// [RL12] Edge field: none, rise, fall, both
// [RL13] Channel 0 value as two bytes
// [RL14] Channel 0 value sets modulator sample rate
// [RL15] Samples signed, two low bits ignored
// [RL16] Channel events set own pending flag
// [RL17] Up/down counts zero to value and back
// [RL18] Capture copies counter into value register
// [RL19] Compare evaluated once per counter update
`timescale 1ns/10ps
module tcc_top
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [1:0] CAP_IN,
  input wire logic RADIO_EVT,
  output logic [1:0] CMP_OUT,
  output logic IRQ
);
  typedef enum logic [1:0] {BUS_IDLE, BUS_DONE} tcc_bus_t;
  tcc_bus_t bus_r;
  tcc_bus_t bus_nxt;
  logic [7:0] ctl0_r;
  logic [7:0] ctl1_r;
  logic [15:0] val0_r;
  logic [15:0] val1_r;
  logic [7:0] timer_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  logic [15:0] cnt_r;
  logic down_r;
  logic [2:0] dsm_div_r;
  logic [15:0] acc_r;
  logic [13:0] sample_r;
  logic [13:0] interp_r;
  logic dsm_bit_r;
  logic dsm_prev_r;
  logic [31:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] idx;
  logic wr_go;
  logic rd_go;
  logic [7:0] wbyte;
  logic tick;
  logic [1:0] tmode;
  logic [15:0] cnt_nxt;
  logic down_nxt;
  logic term_hit;
  logic dsm_on;
  logic dsm_step;
  logic [2:0] dsm_lim;
  logic [15:0] acc_sum;
  logic [13:0] dsm_in;
  logic dsm_out;
  logic [1:0] out_raw;
  logic [1:0] cap_evt;
  logic [1:0] cmp_evt;
  logic [1:0] chan_evt;
  logic [1:0] gated_evt;

  // Bus decode; unmapped reads answer zero and writes are dropped
  assign idx = AVS_ADDRESS[9:2];
  assign wbyte = AVS_WRITEDATA[7:0];
  // Writes land at the edge where waitrequest is seen low
  assign wr_go = AVS_WRITE && bus_r == BUS_DONE && AVS_BYTEENABLE[0];
  assign rd_go = AVS_READ && bus_r == BUS_IDLE;
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && bus_r == BUS_IDLE;
  assign AVS_READDATA = rdata_r;

  // Read mux
  always_comb
  begin
    case (idx)
      tcc_pkg::IDX_CH0_LOW: rdata_nxt = val0_r[7:0];
      tcc_pkg::IDX_CH0_HIGH: rdata_nxt = val0_r[15:8];
      tcc_pkg::IDX_CH1_LOW: rdata_nxt = val1_r[7:0];
      tcc_pkg::IDX_CH1_HIGH: rdata_nxt = val1_r[15:8];
      tcc_pkg::IDX_CTL0: rdata_nxt = ctl0_r;
      tcc_pkg::IDX_CTL1: rdata_nxt = ctl1_r;
      tcc_pkg::IDX_TIMER: rdata_nxt = timer_r;
      tcc_pkg::IDX_IRQ_STAT: rdata_nxt = {6'h00, stat_r};
      tcc_pkg::IDX_IRQ_MASK: rdata_nxt = {6'h00, mask_r};
      tcc_pkg::IDX_COUNT: rdata_nxt = {dsm_out, 7'h00};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // One wait cycle then the answer cycle
  always_comb
  begin
    bus_nxt = BUS_IDLE;
    case (bus_r)
      BUS_IDLE: if (AVS_READ || AVS_WRITE) bus_nxt = BUS_DONE;
      BUS_DONE: bus_nxt = BUS_IDLE;
      default: bus_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      bus_r <= BUS_IDLE;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      bus_r <= bus_nxt;
      if (rd_go) rdata_r <= {24'h000000, rdata_nxt};
    end
  end

  // Counter: tick on every clock while running; prescaling lives elsewhere
  assign tmode = timer_r[1:0];
  assign tick = tmode != tcc_pkg::TM_STOP;
  assign term_hit = cnt_r == val0_r;

  always_comb
  begin
    cnt_nxt = cnt_r;
    down_nxt = down_r;
    case (tmode)
      tcc_pkg::TM_FREE: cnt_nxt = cnt_r + 16'h0001;
      tcc_pkg::TM_MOD: cnt_nxt = term_hit ? tcc_pkg::CNT_ZERO : cnt_r + 16'h0001;
      tcc_pkg::TM_UPDN:
      begin
        // Turn around at the channel 0 value and at zero, see [RL17]
        if (!down_r && term_hit)
        begin
          down_nxt = cnt_r != tcc_pkg::CNT_ZERO;
          cnt_nxt = down_nxt ? cnt_r - 16'h0001 : cnt_r;
        end
        else if (down_r && cnt_r == 16'h0001)
        begin
          down_nxt = 1'b0;
          cnt_nxt = tcc_pkg::CNT_ZERO;
        end
        else
          cnt_nxt = down_r ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
      end
      default: cnt_nxt = cnt_r;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cnt_r <= tcc_pkg::CNT_ZERO;
      down_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      down_r <= down_nxt;
    end
  end

  // Modulator: speed from mode bit, sample rate from channel 0 value
  assign dsm_on = ctl1_r[tcc_pkg::ACT_LSB +: 3] == tcc_pkg::ACT_DSM; // see [RL9]
  assign dsm_lim = ctl1_r[tcc_pkg::MODE_BIT] ? tcc_pkg::DSM_DIV_FAST : tcc_pkg::DSM_DIV_SLOW; // see [RL9]
  assign dsm_step = dsm_on && dsm_div_r == dsm_lim;
  // Interpolator smooths between samples; off means the raw sample, see [RL10]
  assign dsm_in = ctl1_r[1] ? sample_r : interp_r;
  // Sample taken with two low bits dropped, output bit fed back, see [RL15]
  assign acc_sum = acc_r + {{2{dsm_in[13]}}, dsm_in} - (dsm_bit_r ? 16'h2000 : 16'hE000);
  // Shaping drops single-step high pulses; off is the raw bit, see [RL10]
  assign dsm_out = ctl1_r[0] ? dsm_bit_r : (dsm_bit_r && dsm_prev_r);

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      dsm_div_r <= 3'h0;
      acc_r <= 16'h0000;
      sample_r <= 14'h0000;
      interp_r <= 14'h0000;
      dsm_bit_r <= 1'b0;
      dsm_prev_r <= 1'b0;
    end
    else
    begin
      dsm_div_r <= (!dsm_on || dsm_step) ? 3'h0 : dsm_div_r + 3'h1;
      // New sample at each channel 0 terminal count, see [RL14]
      if (dsm_on && tick && term_hit) sample_r <= val1_r[15:2];
      if (dsm_step)
      begin
        interp_r <= interp_r + 14'($signed({sample_r[13], sample_r} - {interp_r[13], interp_r}) >>> 3);
        acc_r <= acc_sum;
        dsm_bit_r <= !acc_sum[15];
        dsm_prev_r <= dsm_bit_r;
      end
    end
  end

  // Channels
  tcc_channel u_ch0
  (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .tick(tick),
    .ctl(ctl0_r),
    .count(cnt_r),
    .down(down_r),
    .cmp_val(val0_r),
    .term_hit(term_hit),
    .cap_in(CAP_IN[0]),
    .radio_evt(RADIO_EVT),
    .out_level(out_raw[0]),
    .cap_evt(cap_evt[0]),
    .cmp_evt(cmp_evt[0])
  );

  tcc_channel u_ch1
  (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .tick(tick),
    .ctl(ctl1_r),
    .count(cnt_r),
    .down(down_r),
    .cmp_val(val1_r),
    .term_hit(term_hit),
    .cap_in(CAP_IN[1]),
    .radio_evt(RADIO_EVT),
    .out_level(out_raw[1]),
    .cap_evt(cap_evt[1]),
    .cmp_evt(cmp_evt[1])
  );

  assign CMP_OUT = {dsm_on ? dsm_out : out_raw[1], out_raw[0]};
  // Channel 1 in modulator mode raises no compare or capture event
  assign chan_evt = {!dsm_on && (cap_evt[1] || cmp_evt[1]), cap_evt[0] || cmp_evt[0]};
  assign gated_evt = chan_evt & {ctl1_r[tcc_pkg::IRQ_EN_BIT], ctl0_r[tcc_pkg::IRQ_EN_BIT]}; // see [RL2]
  assign IRQ = |(stat_r & mask_r);

  // Register writes, captures and sticky flags
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctl0_r <= tcc_pkg::CTL_RESET; // see [RL2]
      ctl1_r <= tcc_pkg::CTL_RESET;
      val0_r <= {tcc_pkg::BYTE_RESET, tcc_pkg::BYTE_RESET}; // see [RL13]
      val1_r <= {tcc_pkg::BYTE_RESET, tcc_pkg::BYTE_RESET};
      timer_r <= tcc_pkg::BYTE_RESET;
      stat_r <= 2'h0;
      mask_r <= 2'h3;
    end
    else
    begin
      if (wr_go && idx == tcc_pkg::IDX_CH0_LOW) val0_r[7:0] <= wbyte; // see [RL13]
      if (wr_go && idx == tcc_pkg::IDX_CH0_HIGH) val0_r[15:8] <= wbyte; // see [RL13]
      if (wr_go && idx == tcc_pkg::IDX_CH1_LOW) val1_r[7:0] <= wbyte;
      if (wr_go && idx == tcc_pkg::IDX_CH1_HIGH) val1_r[15:8] <= wbyte;
      if (wr_go && idx == tcc_pkg::IDX_CTL0) ctl0_r <= wbyte;
      if (wr_go && idx == tcc_pkg::IDX_CTL1) ctl1_r <= wbyte;
      if (wr_go && idx == tcc_pkg::IDX_TIMER) timer_r <= wbyte;
      if (wr_go && idx == tcc_pkg::IDX_IRQ_MASK) mask_r <= wbyte[1:0];
      // Capture wins over a same-cycle software write
      if (cap_evt[0]) val0_r <= cnt_r; // see [RL18]
      if (cap_evt[1] && !dsm_on) val1_r <= cnt_r; // see [RL18]
      // Write one clears; a new event in the same cycle wins, see [RL16]
      if (wr_go && idx == tcc_pkg::IDX_IRQ_STAT)
        stat_r <= (stat_r & ~wbyte[1:0]) | gated_evt;
      else
        stat_r <= stat_r | gated_evt;
    end
  end
endmodule

// >>> test/tcc_chk.sv
// Purpose: port-level assertions for tcc_top
// Assumes: one clock, one wait state per bus access
// Notes: internal state is hidden, so checks tie outputs to bus traffic
`timescale 1ns/10ps
module tcc_chk
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [1:0] CAP_IN,
  input wire logic RADIO_EVT,
  input wire logic [1:0] CMP_OUT,
  input wire logic IRQ
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  // Request and taken-read decode
  wire req_w;
  wire rd_done_w;
  assign req_w = AVS_READ || AVS_WRITE;
  assign rd_done_w = AVS_READ && !AVS_WAITREQUEST;
  chk_wait_first: assert property ($rose(req_w) |-> AVS_WAITREQUEST)
    else $error("no wait state");
  chk_wait_one: assert property (req_w && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("wait too long");
  chk_idle_ready: assert property (!req_w |-> !AVS_WAITREQUEST)
    else $error("wait while idle");
  chk_upper_zero: assert property (rd_done_w |-> AVS_READDATA[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_read_hold: assert property ($changed(AVS_READDATA) |-> $past(AVS_READ))
    else $error("read data moved");
  chk_unmapped_zero: assert property (rd_done_w && AVS_ADDRESS[9:2] == 8'h00 |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_fall: assert property ($fell(IRQ) |-> $past(AVS_WRITE && !AVS_WAITREQUEST))
    else $error("irq dropped alone");
  chk_reset_clear: assert property ($rose(RST_N) |-> CMP_OUT == 2'b00 && !IRQ)
    else $error("outputs not clear");
  // Main scenarios reached
  cover property (rd_done_w);
  cover property ($rose(IRQ));
  cover property ($changed(CMP_OUT));
endmodule
bind tcc_top tcc_chk i_tcc_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .CAP_IN(CAP_IN), .RADIO_EVT(RADIO_EVT),
  .CMP_OUT(CMP_OUT), .IRQ(IRQ));

// >>> test/tcc_pins.sv
// Purpose: model of the capture pins and radio event source
// Assumes: pins synchronous to the system clock
// Notes: settles three clocks so the edge detector has seen it
`timescale 1ns/10ps
module tcc_pins
(
  input wire logic clk,
  output logic [1:0] cap_in,
  output logic radio_evt
);
  // Pins idle low from time zero
  initial
  begin
    cap_in = 2'b00;
    radio_evt = 1'b0;
  end
  // Level change on one capture pin
  task automatic drive(input int ch, input logic v);
    @(posedge clk);
    cap_in[ch] <= v;
    repeat (3) @(posedge clk);
  endtask
  // One-clock radio event pulse
  task automatic radio_pulse();
    @(posedge clk);
    radio_evt <= 1'b1;
    @(posedge clk);
    radio_evt <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule

// >>> test/tb_top.sv
// Purpose: self-checking bench for tcc_top
// Assumes: exactly one wait state, counter moves every clock
// Notes: read expectations queued by the driver, checked by a monitor
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] adr = 10'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic wq;
  logic [1:0] pins;
  logic radio;
  logic [1:0] outs;
  logic irq;
  int miscompares = 0;
  int num_checks = 0;
  logic [31:0] exp_q[$];
  logic [31:0] ev;
  int n;
  logic last;
  logic [7:0] rv;
  tcc_top i_tcc_top (.SYS_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .CAP_IN(pins),
    .RADIO_EVT(radio), .CMP_OUT(outs), .IRQ(irq));
  tcc_pins i_tcc_pins (.clk(clk), .cap_in(pins), .radio_evt(radio));
  // 25 MHz clock
  initial
  begin
    forever #20 clk = ~clk;
  end
  task automatic err(input logic bad, input string m);
    num_checks++;
    if (bad)
    begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // Bus write: hold everything until waitrequest is seen low
  task automatic bw(input logic [7:0] i, input logic [7:0] d, input logic [3:0] b = 4'hF);
    @(posedge clk);
    adr <= {i, 2'b00};
    wd <= {24'h000000, d};
    be <= b;
    wr <= 1'b1;
    @(posedge clk iff wq === 1'b0);
    wr <= 1'b0;
  endtask
  task automatic br(input logic [7:0] i, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    @(posedge clk);
    adr <= {i, 2'b00};
    rd <= 1'b1;
    @(posedge clk iff wq === 1'b0);
    rd <= 1'b0;
  endtask
  // Count output changes over 16 clocks
  task automatic watch(input int ch, output int nc, output logic lv);
    logic prev;
    nc = 0;
    @(negedge clk);
    prev = outs[ch];
    repeat (16)
    begin
      @(negedge clk);
      if (outs[ch] !== prev)
        nc++;
      prev = outs[ch];
    end
    lv = prev;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Oldest note against each read taken
  always @(posedge clk)
    if (rd === 1'b1 && wq === 1'b0)
    begin
      ev = exp_q.pop_front();
      err(rdat !== ev, "read data");
    end
  // Hang guard, well past the expected run
  initial
  begin
    #400000;
    miscompares++;
    complete_run;
  end
  initial
  begin
    void'($urandom(32'hCF35));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped place
    br(8'hE5, 8'h40);
    br(8'hE6, 8'h40);
    br(8'hDA, 8'h00);
    br(8'hDB, 8'h00);
    br(8'hF2, 8'h03);
    br(8'h00, 8'h00);
    // Every edge field, counter pinned at zero by a zero period
    bw(8'hF0, 8'h02);
    for (int e = 0; e < 4; e++)
    begin
      bw(8'hDC, 8'h34);
      bw(8'hE6, {6'h10, e[1:0]});
      i_tcc_pins.drive(1, 1'b1);
      br(8'hDC, e[0] ? 8'h00 : 8'h34);
      bw(8'hDC, 8'h34);
      i_tcc_pins.drive(1, 1'b0);
      br(8'hDC, e[1] ? 8'h00 : 8'h34);
    end
    br(8'hF1, 8'h02);
    @(negedge clk);
    err(irq !== 1'b1, "irq after capture");
    // Masked channel, then radio as capture source
    bw(8'hF1, 8'h02);
    bw(8'hE6, 8'h01);
    i_tcc_pins.drive(1, 1'b1);
    br(8'hF1, 8'h00);
    bw(8'hE6, 8'hC1);
    bw(8'hDC, 8'h34);
    i_tcc_pins.drive(1, 1'b0);
    i_tcc_pins.drive(1, 1'b1);
    br(8'hDC, 8'h34);
    i_tcc_pins.radio_pulse();
    br(8'hDC, 8'h00);
    br(8'hF1, 8'h02);
    bw(8'hF1, 8'h02);
    // Random value; a write with no byte lane must not land
    bw(8'hF0, 8'h00);
    rv = 8'($urandom);
    bw(8'hDA, rv);
    bw(8'hDB, ~rv);
    bw(8'hDA, ~rv, 4'h0);
    br(8'hDA, rv);
    br(8'hDB, ~rv);
    bw(8'hDA, 8'h05);
    bw(8'hDB, 8'h00);
    bw(8'hDC, 8'h02);
    bw(8'hDD, 8'h00);
    // Output actions 000-100 on both channels and 101-110 on channel 1, counting 0 to 5
    for (int c = 0; c < 2; c++)
      for (int a = 0; a < 5 + 2 * c; a++)
      begin
        bw(c ? 8'hE6 : 8'hE5, {2'b01, a[2:0], 3'b100});
        bw(8'hF0, 8'h02);
        watch(c, n, last);
        bw(8'hF0, 8'h00);
        if (a < 2)
          err(last !== (a == 0), "set or clear action");
        else
          err(n < 2, "output never moved");
      end
    // Sticky flags, mask, write-one clear
    br(8'hF1, 8'h03);
    @(negedge clk);
    err(irq !== 1'b1, "irq not raised");
    bw(8'hF2, 8'h00);
    @(negedge clk);
    err(irq !== 1'b0, "masked irq");
    bw(8'hF1, 8'h03);
    br(8'hF1, 8'h00);
    bw(8'hF2, 8'h03);
    // Modulator at the fast rate, zero sample, raw output
    bw(8'hDC, 8'h00);
    bw(8'hDD, 8'h00);
    bw(8'hE6, 8'h7F);
    bw(8'hF0, 8'h02);
    watch(1, n, last);
    bw(8'hF0, 8'h00);
    err(n < 2, "modulator idle");
    complete_run;
  end
endmodule
